// ===== pwm_cond_params.svh
// Register offsets, field positions, reset values and timing counts
`ifndef PWM_COND_PARAMS_SVH
`define PWM_COND_PARAMS_SVH

// ==========================================================================
// Register indices; the byte address is four times the index
`define IDX_POLARITY     8'hD6
`define IDX_FAULT_DATA   8'hD7
`define IDX_CONTROL_2ND  8'hDF
`define IDX_MASK_ENABLE  8'hFB
`define IDX_MASK_LEVEL   8'hFC
`define IDX_CONTROL_1ST  8'hD8
`define IDX_IRQ_STATUS   8'hE0
`define IDX_IRQ_ENABLE   8'hE1
`define IDX_IRQ_CLEAR    8'hE2

// ==========================================================================
// Field positions
`define POS_MODE_LO      3'd6
`define POS_FAULT_IN_EN  3'd3
`define POS_FAULT_FLAG   3'd7
`define POS_FAULT_EDGE   3'd6
`define POS_RUN          3'd7

// ==========================================================================
// Reset values
`define RST_BYTE         8'h00

// ==========================================================================
// Timing: debounce of the fault pin in system clocks
`define DEBOUNCE_CYCLES  4'h8

`endif

// ===== pwm_cond_pkg.sv
// Types shared by the output conditioning stage
package pwm_cond_pkg;

  // ========================================================================
  // Pair mode encodings
  typedef enum logic [1:0] {
    MODE_INDEPENDENT   = 2'h0,
    MODE_COMPLEMENTARY = 2'h1,
    MODE_SYNCHRONOUS   = 2'h2,
    MODE_RESERVED      = 2'h3
  } pair_mode_t;

  // ========================================================================
  // Write request of the register slave
  typedef struct packed {
    logic [7:0] index;
    logic [31:0] data;
    logic [3:0] strb;
  } reg_write_t;

  // Fault detector status carried to the main block
  typedef struct packed {
    logic level;
    logic edge_hit;
  } fault_status_t;

endpackage : pwm_cond_pkg

// ===== fault_pin_filter.sv
// Fault pin synchroniser, debounce and edge detector
`timescale 1ns/1ns
`include "pwm_cond_params.svh"
module fault_pin_filter
  import pwm_cond_pkg::*;
#(
  parameter logic [3:0] DEBOUNCE = `DEBOUNCE_CYCLES
) (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          fault_pin,
  input  wire logic          rising_sel,
  output fault_status_t      status
);

  logic       sync_a;
  logic       sync_b;
  logic       stable;
  logic       armed;
  logic [3:0] count;

  // ========================================================================
  // Two flops before anything looks at the pin
  always_ff @(posedge clk) begin
    if (reset) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= fault_pin;
      sync_b <= sync_a;
    end
  end

  // ========================================================================
  // Level accepted only after it held for the full debounce window
  always_ff @(posedge clk) begin
    if (reset) begin
      count  <= 4'h0;
      stable <= 1'b0;
      armed  <= 1'b0;
    end else if (!armed) begin
      // Adopt the idle level quietly, so reset leaves no false edge
      stable <= sync_b;
      count  <= (count == 4'h3) ? 4'h0 : count + 4'h1;
      armed  <= (count == 4'h3);
    end else if (sync_b == stable) begin
      count <= 4'h0;
    end else if (count == DEBOUNCE - 4'h1) begin
      count  <= 4'h0;
      stable <= sync_b;
    end else begin
      count <= count + 4'h1;
    end
  end

  // ========================================================================
  // Edge of the filtered level in the selected direction
  always_ff @(posedge clk) begin
    if (reset) begin
      status <= '0;
    end else begin
      status.level    <= stable;
      status.edge_hit <= armed && (stable != status.level) &&
                         (stable == rising_sel);
    end
  end

endmodule : fault_pin_filter

// ===== pwm_output_conditioning.sv
// Output conditioning stage of a six-channel, three-pair PWM unit
`timescale 1ns/1ns
`include "pwm_cond_params.svh"
module pwm_output_conditioning
  import pwm_cond_pkg::*;
#(
  parameter int CHANNELS = 6
) (
  input  wire logic                clk,
  input  wire logic                reset,
  // AXI4-Lite slave
  input  wire logic [11:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [11:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Generator side
  input  wire logic [CHANNELS-1:0] raw_channel_signal,
  input  wire logic                adc_compare_event,
  input  wire logic                fault_pin,
  output logic                     run_bit,
  output logic                     counter_reset,
  // Pins and interrupt
  output logic [CHANNELS-1:0]      pwm_out,
  output logic                     irq
);

  // ========================================================================
  // Registers
  logic [7:0]     polarity_reg;
  logic [7:0]     fault_brake_data_reg;
  logic [7:0]     second_control_reg;
  logic [7:0]     mask_enable_reg;
  logic [7:0]     mask_level_reg;
  logic [7:0]     first_control_reg;
  logic           irq_status;
  logic           irq_enable;
  logic           brake_active;
  fault_status_t  fault_stat;
  pair_mode_t     pair_mode_field;
  logic           fault_pin_input_enable;
  logic           fault_edge_select;
  logic           brake_event;

  // Write channel state
  logic           aw_held;
  logic           w_held;
  logic [7:0]     aw_index;
  logic [31:0]    w_data;
  logic [3:0]     w_strb;
  reg_write_t     wr;
  logic           wr_fire;
  logic           wr_known;

  assign pair_mode_field        = pair_mode_t'(second_control_reg[7:6]);
  assign fault_pin_input_enable = second_control_reg[`POS_FAULT_IN_EN];
  assign fault_edge_select      = fault_brake_data_reg[`POS_FAULT_EDGE];

  // ========================================================================
  // Byte address to register index; the low two address bits are ignored
  function automatic logic [7:0] addr_index(input logic [11:0] a);
    addr_index = a[9:2];
  endfunction : addr_index

  function automatic logic index_known(input logic [7:0] i);
    case (i)
      `IDX_POLARITY, `IDX_FAULT_DATA, `IDX_CONTROL_2ND,
      `IDX_MASK_ENABLE, `IDX_MASK_LEVEL, `IDX_CONTROL_1ST,
      `IDX_IRQ_STATUS, `IDX_IRQ_ENABLE, `IDX_IRQ_CLEAR:
        index_known = 1'b1;
      default:
        index_known = 1'b0;
    endcase
  endfunction : index_known

  // ========================================================================
  // Fault pin filter
  fault_pin_filter #(
    .DEBOUNCE (`DEBOUNCE_CYCLES)
  ) u_filter (
    .clk        (clk),
    .reset      (reset),
    .fault_pin  (fault_pin),
    .rising_sel (fault_edge_select),
    .status     (fault_stat)
  );

  // Enabled fault pin edge and ungated ADC compare event brake the same way
  assign brake_event = (fault_stat.edge_hit &&
                        fault_pin_input_enable) ||
                       adc_compare_event;

  // ========================================================================
  // AXI write address and data capture, either order
  assign wr_fire  = aw_held && w_held && !s_axi_bvalid;
  assign wr.index = aw_index;
  assign wr.data  = w_data;
  assign wr.strb  = w_strb;
  assign wr_known = index_known(wr.index);

  always_ff @(posedge clk) begin
    if (reset) begin
      aw_held       <= 1'b0;
      aw_index      <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held  <= 1'b1;
        aw_index <= addr_index(s_axi_awaddr);
        s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      w_held       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response: DECERR for an unmapped address
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? 2'h0 : 2'h3;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ========================================================================
  // Plain configuration registers, low byte lane only
  always_ff @(posedge clk) begin
    if (reset) begin
      polarity_reg       <= `RST_BYTE;
      second_control_reg <= `RST_BYTE;
      mask_enable_reg    <= `RST_BYTE;
      mask_level_reg     <= `RST_BYTE;
      irq_enable         <= 1'b0;
    end else if (wr_fire && wr.strb[0]) begin
      case (wr.index)
        `IDX_POLARITY:    polarity_reg       <= {2'h0, wr.data[5:0]};
        `IDX_CONTROL_2ND: second_control_reg <= wr.data[7:0];
        `IDX_MASK_ENABLE: mask_enable_reg    <= {2'h0, wr.data[5:0]};
        `IDX_MASK_LEVEL:  mask_level_reg     <= {2'h0, wr.data[5:0]};
        `IDX_IRQ_ENABLE:  irq_enable         <= wr.data[0];
        default:          ;
      endcase
    end
  end

  // ========================================================================
  // Fault data register; hardware set of the flag wins over a clear
  always_ff @(posedge clk) begin
    if (reset) begin
      fault_brake_data_reg <= `RST_BYTE;
    end else begin
      if (wr_fire && wr.strb[0] && wr.index == `IDX_FAULT_DATA) begin
        fault_brake_data_reg <= wr.data[7:0];
      end
      if (brake_event) begin
        fault_brake_data_reg[`POS_FAULT_FLAG] <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Run bit: software sets, brake clears with priority
  always_ff @(posedge clk) begin
    if (reset) begin
      first_control_reg <= `RST_BYTE;
    end else if (brake_event) begin
      first_control_reg[`POS_RUN] <= 1'b0;
    end else if (wr_fire && wr.strb[0] &&
                 wr.index == `IDX_CONTROL_1ST) begin
      first_control_reg <= wr.data[7:0];
    end
  end

  // ========================================================================
  // Brake state holds until the run bit is written to one again
  always_ff @(posedge clk) begin
    if (reset) begin
      brake_active <= 1'b0;
    end else if (brake_event) begin
      brake_active <= 1'b1;
    end else if (wr_fire && wr.strb[0] && wr.data[`POS_RUN] &&
                 wr.index == `IDX_CONTROL_1ST) begin
      brake_active <= 1'b0;
    end
  end

  // Counter reset pulse and run level to the generator
  always_ff @(posedge clk) begin
    if (reset) begin
      counter_reset <= 1'b0;
      run_bit       <= 1'b0;
    end else begin
      counter_reset <= brake_event;
      run_bit       <= first_control_reg[`POS_RUN] && !brake_event;
    end
  end

  // ========================================================================
  // Interrupt status: sticky, set wins over write-one-to-clear
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_status <= 1'b0;
    end else if (brake_event) begin
      irq_status <= 1'b1;
    end else if (wr_fire && wr.strb[0] && wr.data[0] &&
                 wr.index == `IDX_IRQ_CLEAR) begin
      irq_status <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_status && irq_enable;
    end
  end

  // ========================================================================
  // Read channel, one answer per request
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= index_known(addr_index(s_axi_araddr)) ?
                         2'h0 : 2'h3;
        case (addr_index(s_axi_araddr))
          `IDX_POLARITY:    s_axi_rdata <= {24'h0, polarity_reg};
          `IDX_FAULT_DATA:  s_axi_rdata <= {24'h0, fault_brake_data_reg};
          `IDX_CONTROL_2ND: s_axi_rdata <= {24'h0, second_control_reg};
          `IDX_MASK_ENABLE: s_axi_rdata <= {24'h0, mask_enable_reg};
          `IDX_MASK_LEVEL:  s_axi_rdata <= {24'h0, mask_level_reg};
          `IDX_CONTROL_1ST: s_axi_rdata <= {24'h0, first_control_reg};
          `IDX_IRQ_STATUS:  s_axi_rdata <= {31'h0, irq_status};
          `IDX_IRQ_ENABLE:  s_axi_rdata <= {31'h0, irq_enable};
          default:          s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Channel path: mode, then mask, then brake, then polarity
  logic [CHANNELS-1:0] moded;
  logic [CHANNELS-1:0] masked;
  logic [CHANNELS-1:0] braked;

  always_comb begin
    moded = raw_channel_signal;
    for (int p = 0; p < CHANNELS; p += 2) begin
      case (pair_mode_field)
        MODE_COMPLEMENTARY:
          moded[p+1] = !raw_channel_signal[p];
        MODE_SYNCHRONOUS:
          moded[p+1] = raw_channel_signal[p];
        // Reserved code behaves as independent
        default:
          moded[p+1] = raw_channel_signal[p+1];
      endcase
    end
  end

  // Mask and brake overrides, brake highest priority
  assign masked = (moded & ~mask_enable_reg[CHANNELS-1:0]) |
                  (mask_level_reg[CHANNELS-1:0] &
                   mask_enable_reg[CHANNELS-1:0]);
  assign braked = brake_active ?
                  fault_brake_data_reg[CHANNELS-1:0] :
                  masked;

  // Polarity last, straight from a flop to the pins
  always_ff @(posedge clk) begin
    if (reset) begin
      pwm_out <= '0;
    end else begin
      pwm_out <= braked ^ polarity_reg[CHANNELS-1:0];
    end
  end

endmodule : pwm_output_conditioning

// ===== pwm_output_conditioning_props.sv
// Concurrent checks on the ports of the output conditioning stage
`timescale 1ns/1ns
module pwm_output_conditioning_chk #(
  parameter int CHANNELS = 6
) (
  input wire logic                clk,
  input wire logic                reset,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic                adc_compare_event,
  input wire logic                run_bit,
  input wire logic                counter_reset,
  input wire logic [CHANNELS-1:0] pwm_out,
  input wire logic                irq
);
  // ==========================================================
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_reset_quiet: assert property (disable iff (1'b0) reset |=>
    (pwm_out == '0 && !irq && !run_bit && !counter_reset))
    else $error("outputs not quiet after reset");
  a_brake_stops_run: assert property (adc_compare_event |->
    ##[1:3] !run_bit) else $error("brake left run bit set");
  a_brake_clears_count: assert property (adc_compare_event |->
    ##[1:3] counter_reset) else $error("no counter reset on brake");
  a_count_pulse_once: assert property (counter_reset |=>
    !counter_reset) else $error("counter reset longer than a cycle");
  a_count_while_stop: assert property (counter_reset |->
    !run_bit) else $error("counter reset while running");
  // Run only comes back through a register write
  a_run_needs_write: assert property ($rose(run_bit) |->
    $past(s_axi_bvalid)) else $error("run rose without a write");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer moved");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer moved");

  c_adc_brake: cover property (adc_compare_event ##[1:3] counter_reset);
  c_read_stall: cover property (s_axi_rvalid && !s_axi_rready);
  c_irq_up: cover property ($rose(irq));
endmodule : pwm_output_conditioning_chk

bind pwm_output_conditioning pwm_output_conditioning_chk #(
  .CHANNELS(CHANNELS)
) u_chk (
  .clk(clk), .reset(reset), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .adc_compare_event(adc_compare_event),
  .run_bit(run_bit), .counter_reset(counter_reset),
  .pwm_out(pwm_out), .irq(irq)
);

// ===== power_stage_model.sv
// Far side model: power stage driving the fault line to its active level on a trip
`timescale 1ns/1ns
module power_stage_model (
  input  wire logic       clk,
  input  wire logic       trip,
  input  wire logic       rising_sense,
  input  wire logic [4:0] hold,
  output logic            fault_pin
);
  logic [4:0] left;

  // ==========================================================
  // Trip holds the fault level for hold cycles; short holds
  // model noise that the pin filter must reject
  initial left = 5'h00;
  always @(posedge clk) begin
    if (trip) begin
      left <= hold;
    end else if (left != 5'h00) begin
      left <= left - 5'h01;
    end
  end
  // Idle level is the opposite of the sensed edge direction
  assign fault_pin = (left != 5'h00) ~^ rising_sense;
endmodule : power_stage_model

// ===== pwm_output_conditioning_tb.sv
// Self-checking testbench of the output conditioning stage
`timescale 1ns/1ns
`include "pwm_cond_params.svh"
module pwm_output_conditioning_tb;
  import pwm_cond_pkg::*;
  logic        clk, reset, awv, wv, bry, arv, rry, adc, trip, rise;
  logic        awr, wr_rdy, bv, arr, rv, run, crst, irq, fpin;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat, r32;
  logic [1:0]  bresp, rresp, mode;
  logic [3:0]  ws;
  logic [4:0]  hold;
  logic [5:0]  raw, pins, men, mlv, pol, fbd;
  logic        brk;
  logic [33:0] exp_q[$];
  int          seed, n_mismatch, checks;

  pwm_output_conditioning u_dut (.clk(clk), .reset(reset),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rry), .raw_channel_signal(raw),
    .adc_compare_event(adc), .fault_pin(fpin), .run_bit(run),
    .counter_reset(crst), .pwm_out(pins), .irq(irq));
  power_stage_model u_stage (.clk(clk), .trip(trip),
    .rising_sense(rise), .hold(hold), .fault_pin(fpin));

  // ==========================================================
  // Clock, result monitor and watchdog
  always #10 clk = ~clk;
  always @(posedge clk) if (rv && rry) check({rresp, rdat}, exp_q.pop_front());
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end

  task automatic check(input logic [33:0] seen, input logic [33:0] e);
    checks++;
    if (seen !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, e);
    end
  endtask : check

  task automatic stop_test();
    if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // ==========================================================
  // Bus master: write releases each channel when taken
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk);
    awa <= {2'b00, idx, 2'b00}; wd <= d; awv <= 1'b1; wv <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
    end while ((awv && !awr) || (wv && !wr_rdy));
    r32 = $random(seed);
    repeat (r32[1:0]) @(posedge clk); // Random stall before bready
    bry <= 1'b1;
    do @(posedge clk); while (!bv);
    check(bresp, (idx == 8'h10) ? 2'h3 : 2'h0);
    bry <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [33:0] e);
    @(posedge clk);
    exp_q.push_back(e);
    ara <= {2'b00, idx, 2'b00}; arv <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    r32 = $random(seed);
    repeat (r32[1:0]) @(posedge clk);
    rry <= 1'b1;
    do @(posedge clk); while (!rv);
    rry <= 1'b0;
  endtask : rd

  // Order: pair mode, mask, brake, then polarity
  function automatic logic [5:0] exp_pins();
    logic [5:0] g;
    g = raw;
    for (int i = 1; i < 6; i += 2) begin
      if (mode == MODE_COMPLEMENTARY) g[i] = ~raw[i-1];
      if (mode == MODE_SYNCHRONOUS) g[i] = raw[i-1];
    end
    g = (g & ~men) | (mlv & men);
    if (brk) g = fbd;
    return g ^ pol;
  endfunction : exp_pins

  task automatic pins_ok();
    r32 = $random(seed);
    raw <= r32[5:0];
    repeat (3) @(posedge clk);
    check(pins, exp_pins());
  endtask : pins_ok

  task automatic trip_for(input logic [4:0] h);
    @(posedge clk);
    hold <= h; trip <= 1'b1;
    @(posedge clk);
    trip <= 1'b0;
    repeat (30) @(posedge clk);
  endtask : trip_for

  // ==========================================================
  // Main sequence
  initial begin
    seed = 28813; clk = 0; reset = 1; awv = 0; wv = 0; bry = 0; arv = 0;
    rry = 0; adc = 0; trip = 0; rise = 0; awa = 0; ara = 0; wd = 0;
    ws = 4'hF; hold = 0; raw = 0; mode = 0; men = 0; mlv = 0; pol = 0;
    fbd = 0; brk = 0; n_mismatch = 0; checks = 0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rd(`IDX_MASK_ENABLE, 34'h0);
    rd(`IDX_CONTROL_2ND, 34'h0);
    rd(8'h10, {2'h3, 32'h0});
    wr(8'h10, 32'h1);
    wr(`IDX_CONTROL_1ST, 32'h80);
    for (int m = 0; m < 4; m++) repeat (3) begin
      mode = m[1:0];
      r32 = $random(seed); men = r32[5:0]; mlv = r32[13:8];
      pol = r32[21:16];
      wr(`IDX_CONTROL_2ND, {24'h0, mode, 6'h0});
      wr(`IDX_MASK_ENABLE, {26'h0, men});
      wr(`IDX_MASK_LEVEL, {26'h0, mlv});
      wr(`IDX_POLARITY, {26'h0, pol});
      rd(`IDX_MASK_LEVEL, {28'h0, mlv});
      pins_ok();
    end
    // A write without the low byte lane changes nothing
    ws <= 4'hE;
    wr(`IDX_MASK_LEVEL, {26'h0, ~mlv});
    ws <= 4'hF;
    rd(`IDX_MASK_LEVEL, {28'h0, mlv});
    // ADC compare brake, interrupt mask and clear
    fbd = r32[29:24];
    wr(`IDX_IRQ_ENABLE, 32'h1);
    wr(`IDX_FAULT_DATA, {26'h0, fbd});
    @(posedge clk) adc <= 1'b1;
    @(posedge clk) adc <= 1'b0;
    brk = 1;
    repeat (4) @(posedge clk);
    check(run, 1'b0);
    check(irq, 1'b1);
    pins_ok();
    rd(`IDX_FAULT_DATA, {26'h2, fbd});
    rd(`IDX_IRQ_STATUS, 34'h1);
    wr(`IDX_IRQ_ENABLE, 32'h0);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    wr(`IDX_IRQ_ENABLE, 32'h1);
    wr(`IDX_FAULT_DATA, {26'h0, fbd});
    rd(`IDX_FAULT_DATA, {28'h0, fbd});
    pins_ok();
    wr(`IDX_IRQ_CLEAR, 32'h1);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    wr(`IDX_CONTROL_1ST, 32'h80);
    brk = 0;
    pins_ok();
    // Fault pin: input enable, noise rejection, both edges
    mode = 0;
    for (int e = 0; e < 2; e++) begin
      rise <= e[0];
      wr(`IDX_CONTROL_2ND, 32'h0);
      wr(`IDX_FAULT_DATA, {25'h0, e[0], fbd});
      trip_for(5'd20);
      check(run, 1'b1);
      wr(`IDX_CONTROL_2ND, 32'h8);
      trip_for(5'd4);
      check(run, 1'b1);
      trip_for(5'd20);
      check(run, 1'b0);
      brk = 1;
      pins_ok();
      rd(`IDX_FAULT_DATA, {25'h1, e[0], fbd});
      wr(`IDX_CONTROL_1ST, 32'h80);
      brk = 0;
      pins_ok();
    end
    stop_test();
  end
endmodule : pwm_output_conditioning_tb
